// ==== bench/burst_sink.sv ====
// partner: sink on the burst output, stalls one cycle in four
// assumes one clock and reset presetn
`timescale 1ns/100ps
`default_nettype none
module burst_sink (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic valid,
  input wire logic [31:0] data,
  input wire logic last,
  output logic ready,
  output logic got,
  output logic [31:0] got_data,
  output logic got_last
);
  logic [7:0] lfsr;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lfsr <= 8'hA5;
      ready <= 1'b0;
      got <= 1'b0;
    end else begin
      lfsr <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
      ready <= lfsr[0] | lfsr[1];
      got <= valid && ready;
      got_data <= data;
      got_last <= last;
    end
  end
endmodule // burst_sink
`default_nettype wire

// ==== bench/sbc_properties.sv ====
// checker: apb answer, burst output hold, effective levels seen on reads
// assumes the ports of source_burst_config on one clock
`timescale 1ns/100ps
`default_nettype none
`include "burst_cfg_consts.vh"
module sbc_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic fifo_near_full_low,
  input wire logic burst_out_valid,
  input wire logic burst_out_ready,
  input wire logic [31:0] burst_out_data,
  input wire logic burst_out_last
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic rd;
  assign rd = pready && !pwrite;
  ////////////////////////////////////////////////////////////////
  a_ready_setup: assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
  a_err_unmapped: assert property (pready && paddr > `OFF_POP |-> pslverr)
    else $error("unmapped access not refused");
  a_valid_hold: assert property (burst_out_valid && !burst_out_ready |=>
    burst_out_valid && $stable(burst_out_data)) else $error("burst word dropped");
  a_last_hold: assert property (burst_out_valid && !burst_out_ready |=>
    $stable(burst_out_last)) else $error("burst end moved");
  a_eff_on_range: assert property (rd && paddr == `OFF_EFF_LVL |->
    prdata[8:0] >= `LVL_MIN && prdata[8:0] <= `LVL_MAX) else $error("on level out of range");
  a_eff_off_order: assert property (rd && paddr == `OFF_EFF_LVL |->
    prdata[24:16] >= prdata[8:0] && prdata[24:16] <= `LVL_MAX) else $error("off level bad");
  a_burst_nonzero: assert property (rd && paddr == `OFF_STATUS |->
    prdata[19:14] != 6'h00) else $error("burst length zero");
  a_near_full_flag: assert property (rd && paddr == `OFF_STATUS |->
    prdata[12] == !$past(fifo_near_full_low)) else $error("near full flag mismatch");
  a_used_bound: assert property (rd && paddr == `OFF_STATUS |->
    prdata[8:0] <= `FIFO_DEPTH) else $error("fill above depth");
endmodule // sbc_props
bind source_burst_config sbc_props sbc_props_inst (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .fifo_near_full_low(fifo_near_full_low),
  .burst_out_valid(burst_out_valid), .burst_out_ready(burst_out_ready),
  .burst_out_data(burst_out_data), .burst_out_last(burst_out_last));
`default_nettype wire

// ==== bench/source_burst_config_bench.sv ====
// bench: reset values, clamps, refusal, release policy, near-full hysteresis
// assumes the design under hw/ and the sink model
`timescale 1ns/100ps
`default_nettype none
`include "burst_cfg_consts.vh"
module source_burst_config_bench;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, seed = 32'd42742;
  logic [31:0] prdata, rdata, bd, gd;
  logic [32:0] q[$];
  logic pready, pslverr, err, nfl, bv, br, bl, got, gl;
  int n_errors = 0, checks_done = 0, used = 0, nf = 0;
  int on, off, eb, k;
  always #50 pclk = ~pclk;
  source_burst_config source_burst_config_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .fifo_near_full_low(nfl), .burst_out_valid(bv),
    .burst_out_ready(br), .burst_out_data(bd), .burst_out_last(bl));
  burst_sink burst_sink_inst (.pclk(pclk), .presetn(presetn), .valid(bv), .data(bd),
    .last(bl), .ready(br), .got(got), .got_data(gd), .got_last(gl));
  ////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic int clamp(input int v, input int lo);
    return v < lo ? lo : (v > 508 ? 508 : v);
  endfunction
  task automatic final_report();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value at %0t: %h vs %h", $time, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int t;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    t = 0;
    do begin
      @(posedge pclk);
      t++;
    end while (pready !== 1'b1 && t < 20);
    rdata = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (t >= 20) begin
      n_errors++;
      final_report();
    end
  endtask
  // kind 1 pops one credit once the buffer has room, else pushes one
  task automatic credit(input int kind, input logic [31:0] d, input logic last);
    int t;
    t = 0;
    if (kind == 1) begin
      do begin
        apb(0, `OFF_STATUS, 0);
        t++;
      end while (rdata[10] !== 1'b1 && t < 40);
      if (t >= 40) begin
        n_errors++;
        final_report();
      end
      q.push_back({last, d});
      apb(1, `OFF_POP, d);
      used--;
    end else begin
      apb(1, `OFF_PUSH, d);
      used++;
    end
    repeat (2) @(posedge pclk);
    if (508 - used <= on)
      nf = 1;
    else if (508 - used >= off)
      nf = 0;
    cmp({31'h0, nfl}, {31'h0, nf == 0});
  endtask
  always @(posedge pclk) begin
    if (got === 1'b1) begin
      if (q.size() == 0)
        cmp(gd, ~gd);
      else begin
        cmp({31'h0, gl}, {31'h0, q[0][32]});
        cmp(gd, q[0][31:0]);
        void'(q.pop_front());
      end
    end
  end
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, `OFF_BURST, 0);
    cmp(rdata, 32'h1);
    apb(0, `OFF_EFF_LVL, 0);
    cmp(rdata, 32'h00010001);
    apb(0, 12'h024, 0);
    cmp({31'h0, err}, 32'h1);
    $display("done reset");
    for (k = 0; k < 12; k++) begin
      eb = k < 2 ? 0 : rnd() % 64;
      on = k == 4 ? 0 : rnd() % 512;
      off = k == 5 ? 511 : rnd() % 512;
      apb(1, `OFF_CTRL, {30'h0, k[0], 1'b0});
      apb(1, `OFF_BURST, eb);
      apb(1, `OFF_ON_LVL, on);
      apb(1, `OFF_OFF_LVL, off);
      eb = eb == 0 ? 1 : eb;
      on = clamp(on, k[0] ? eb : 1);
      off = clamp(off, on);
      apb(0, `OFF_EFF_LVL, 0);
      cmp(rdata, {7'h0, off[8:0], 7'h0, on[8:0]});
      apb(0, `OFF_STATUS, 0);
      cmp({26'h0, rdata[19:14]}, eb);
    end
    apb(1, `OFF_CAL, 32'h0001A516);
    apb(0, `OFF_CAL, 0);
    cmp(rdata, 32'h0001A516);
    // burst and calendar writes while enabled are dropped
    apb(1, `OFF_CTRL, 32'h1);
    apb(1, `OFF_BURST, 32'h9);
    apb(1, `OFF_CAL, 32'h00000303);
    apb(0, `OFF_STATUS, 0);
    cmp({26'h0, rdata[19:14]}, eb);
    apb(0, `OFF_CAL, 0);
    cmp(rdata, 32'h0001A516);
    $display("done clamps");
    on = 200;
    off = 300;
    apb(1, `OFF_CTRL, 32'h2);
    apb(1, `OFF_BURST, 32'h4);
    apb(1, `OFF_ON_LVL, on);
    apb(1, `OFF_OFF_LVL, off);
    apb(1, `OFF_CTRL, 32'h3);
    for (k = 0; k < 4; k++) begin
      apb(0, `OFF_STATUS, 0);
      cmp({31'h0, rdata[11]}, 32'h0);
      credit(0, 0, 0);
    end
    apb(0, `OFF_STATUS, 0);
    cmp({31'h0, rdata[11]}, 32'h1);
    credit(0, 1, 0);
    for (k = 0; k < 5; k++)
      credit(1, rnd(), k >= 3);
    $display("done policy one");
    on = 500;
    off = 504;
    apb(1, `OFF_CTRL, 0);
    apb(1, `OFF_BURST, 32'h3);
    apb(1, `OFF_ON_LVL, on);
    apb(1, `OFF_OFF_LVL, off);
    apb(1, `OFF_CTRL, 32'h1);
    credit(0, 0, 0);
    apb(0, `OFF_STATUS, 0);
    cmp({31'h0, rdata[11]}, 32'h1);
    for (k = 0; k < 8; k++)
      credit(0, 0, 0);
    for (k = 0; k < 9; k++)
      credit(1, rnd(), k % 3 == 2);
    $display("done near full");
    k = 0;
    while (q.size() > 0 && k < 200) begin
      @(posedge pclk);
      k++;
    end
    if (k >= 200)
      n_errors++;
    final_report();
  end
endmodule // source_burst_config_bench
`default_nettype wire

// ==== hw/burst_cfg_consts.vh ====
// constants for the source burst configuration block
// assumes inclusion by bare name from hw/ design files
`ifndef BURST_CFG_CONSTS_VH
`define BURST_CFG_CONSTS_VH
// register offsets (byte addresses, one aligned word each)
`define OFF_CTRL 12'h000
`define OFF_BURST 12'h004
`define OFF_ON_LVL 12'h008
`define OFF_OFF_LVL 12'h00C
`define OFF_CAL 12'h010
`define OFF_STATUS 12'h014
`define OFF_EFF_LVL 12'h018
`define OFF_PUSH 12'h01C
`define OFF_POP 12'h020
// field positions
`define CTRL_ENABLE_BIT 0
`define CTRL_POLICY_BIT 1
`define PUSH_EOP_BIT 0
`define CAL_REPEAT_LSB 0
`define CAL_LEN_LSB 8
// reset values
`define RST_BURST 6'h01
`define RST_ON_LVL 9'h001
`define RST_OFF_LVL 9'h001
// limits
`define LVL_MAX 9'h1FC
`define LVL_MIN 9'h001
`define BURST_MIN 6'h01
`define FIFO_DEPTH 9'h1FC
`endif

// ==== hw/cfg_clamp.v ====
// cfg_clamp: clamps a value into a window [lo, hi]
// assumes lo <= hi from the caller
`timescale 1ns/100ps
`default_nettype none
module cfg_clamp #(
  parameter W = 9
) (
  input wire [W-1:0] value,
  input wire [W-1:0] lo,
  input wire [W-1:0] hi,
  output wire [W-1:0] result
);
  // raise below lo, lower above hi
  assign result = (value < lo) ? lo : ((value > hi) ? hi : value);
endmodule // cfg_clamp
`default_nettype wire

// ==== hw/skid_buf2.v ====
// skid_buf2: two-entry buffer with valid/ready on both sides
// assumes one clock, asynchronous active-low reset
`timescale 1ns/100ps
`default_nettype none
module skid_buf2 #(
  parameter W = 33
) (
  input wire pclk,
  input wire presetn,
  input wire in_valid,
  output wire in_ready,
  input wire [W-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [W-1:0] out_data
);
  reg [W-1:0] mem_ff [0:1];
  reg rd_ptr_ff;
  reg wr_ptr_ff;
  reg [1:0] cnt_ff;
  wire push;
  wire pop;
  assign in_ready = (cnt_ff != 2'h2);
  assign out_valid = (cnt_ff != 2'h0);
  assign out_data = mem_ff[rd_ptr_ff];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_ptr_ff <= 1'b0;
      wr_ptr_ff <= 1'b0;
      cnt_ff <= 2'h0;
      mem_ff[0] <= {W{1'b0}};
      mem_ff[1] <= {W{1'b0}};
    end else begin
      if (push) begin
        mem_ff[wr_ptr_ff] <= in_data;
        wr_ptr_ff <= ~wr_ptr_ff;
      end
      if (pop) begin
        rd_ptr_ff <= ~rd_ptr_ff;
      end
      if (push & ~pop) begin
        cnt_ff <= cnt_ff + 2'h1;
      end else if (pop & ~push) begin
        cnt_ff <= cnt_ff - 2'h1;
      end
    end
  end
endmodule // skid_buf2
`default_nettype wire

// ==== hw/source_burst_config.v ====
// source_burst_config: release policy, burst length and near-full levels
// for a source fifo, reached over apb; one clock stands for both domains
//
// Added by the designer: the register offsets and the APB slave port.
`timescale 1ns/100ps
`default_nettype none
`include "burst_cfg_consts.vh"
module source_burst_config #(
  parameter DEPTH = 9'h1FC
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  output reg fifo_near_full_low,
  output reg burst_out_valid,
  input wire burst_out_ready,
  output reg [31:0] burst_out_data,
  output reg burst_out_last
);
  ////////////////////////////////////////////////////////////////////////////
  // configuration registers
  reg source_enable_ctl_ff;
  reg release_policy_select_ff;
  reg [5:0] max_burst_credits_ff;
  reg [8:0] near_full_on_level_ff;
  reg [8:0] near_full_off_level_ff;
  reg [7:0] calendar_repeat_count_ff;
  reg [8:0] calendar_sequence_length_ff;
  // apb decode
  wire setup;
  wire wr_acc;
  wire hit;
  assign setup = psel & ~penable;
  assign wr_acc = psel & penable & pready & pwrite;
  assign hit = (paddr == `OFF_CTRL) | (paddr == `OFF_BURST) | (paddr == `OFF_ON_LVL) |
               (paddr == `OFF_OFF_LVL) | (paddr == `OFF_CAL) | (paddr == `OFF_STATUS) |
               (paddr == `OFF_EFF_LVL) | (paddr == `OFF_PUSH) | (paddr == `OFF_POP);
  ////////////////////////////////////////////////////////////////////////////
  // effective values
  wire [5:0] eff_burst;
  wire [8:0] burst_w;
  wire [8:0] on_lo;
  wire [8:0] eff_on;
  wire [8:0] off_lo;
  wire [8:0] eff_off;
  wire [8:0] lvl_max;
  assign lvl_max = `LVL_MAX;
  // zero is the only illegal burst length
  assign eff_burst = (max_burst_credits_ff == 6'h00) ? `BURST_MIN : max_burst_credits_ff;
  assign burst_w = {3'h0, eff_burst};
  assign on_lo = release_policy_select_ff ? burst_w : `LVL_MIN;
  cfg_clamp #(.W(9)) u_on_clamp (
    .value(near_full_on_level_ff),
    .lo(on_lo),
    .hi(lvl_max),
    .result(eff_on)
  );
  // eff_on never exceeds 508 so the window stays ordered
  assign off_lo = eff_on;
  cfg_clamp #(.W(9)) u_off_clamp (
    .value(near_full_off_level_ff),
    .lo(off_lo),
    .hi(lvl_max),
    .result(eff_off)
  );
  ////////////////////////////////////////////////////////////////////////////
  // source fifo occupancy model, credits pushed and popped by software
  reg [8:0] used_ff;
  reg eop_pending_ff;
  reg [5:0] burst_cnt_ff;
  wire [8:0] free_cnt;
  wire push_req;
  wire pop_req;
  wire release_ok;
  wire buf_in_ready;
  wire buf_in_valid;
  wire buf_out_valid;
  wire [32:0] buf_out_data;
  wire [32:0] buf_in_data;
  wire buf_pop;
  assign free_cnt = DEPTH - used_ff;
  assign push_req = wr_acc & (paddr == `OFF_PUSH) & (used_ff != DEPTH);
  assign pop_req = wr_acc & (paddr == `OFF_POP);
  // policy zero: one credit or eop suffices; policy one: full burst or eop
  assign release_ok = source_enable_ctl_ff & (used_ff != 9'h000) &
                      (release_policy_select_ff ? (eop_pending_ff | (used_ff >= burst_w))
                                                : 1'b1);
  assign buf_in_valid = release_ok & pop_req;
  // last marks burst end: segment at burst length or at eop
  assign buf_in_data = {(burst_cnt_ff + 6'h01 == eff_burst) | (eop_pending_ff &
                        (used_ff == 9'h001)), pwdata};
  assign buf_pop = burst_out_valid & burst_out_ready;
  skid_buf2 #(.W(33)) u_buf (
    .pclk(pclk),
    .presetn(presetn),
    .in_valid(buf_in_valid),
    .in_ready(buf_in_ready),
    .in_data(buf_in_data),
    .out_valid(buf_out_valid),
    .out_ready(buf_pop | ~burst_out_valid),
    .out_data(buf_out_data)
  );
  wire took;
  assign took = buf_in_valid & buf_in_ready;
  reg [8:0] nxt_used;
  reg nxt_eop_pending;
  reg [5:0] nxt_burst_cnt;
  always @* begin
    nxt_used = used_ff;
    nxt_eop_pending = eop_pending_ff;
    nxt_burst_cnt = burst_cnt_ff;
    // a refused pop leaves the fill alone; software sees it in status
    if (push_req & ~took) begin
      nxt_used = used_ff + 9'h001;
    end else if (took & ~push_req) begin
      nxt_used = used_ff - 9'h001;
    end
    // set wins over clear
    if (push_req & pwdata[`PUSH_EOP_BIT]) begin
      nxt_eop_pending = 1'b1;
    end else if (took & (used_ff == 9'h001)) begin
      nxt_eop_pending = 1'b0;
    end
    if (took) begin
      if (buf_in_data[32]) begin
        nxt_burst_cnt = 6'h00;
      end else begin
        nxt_burst_cnt = burst_cnt_ff + 6'h01;
      end
    end
  end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      used_ff <= 9'h000;
      eop_pending_ff <= 1'b0;
      burst_cnt_ff <= 6'h00;
    end else begin
      used_ff <= nxt_used;
      eop_pending_ff <= nxt_eop_pending;
      burst_cnt_ff <= nxt_burst_cnt;
    end
  end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      burst_out_valid <= 1'b0;
      burst_out_data <= 32'h00000000;
      burst_out_last <= 1'b0;
    end else if (buf_pop | ~burst_out_valid) begin
      burst_out_valid <= buf_out_valid;
      burst_out_data <= buf_out_data[31:0];
      burst_out_last <= buf_out_data[32];
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // near-full with hysteresis
  localparam NF_CLEAR = 1'b0;
  localparam NF_SET = 1'b1;
  reg nf_state_ff;
  reg nxt_nf_state;
  always @* begin
    nxt_nf_state = nf_state_ff;
    case (nf_state_ff)
      NF_CLEAR: begin
        if (free_cnt <= eff_on) begin
          nxt_nf_state = NF_SET;
        end
      end
      NF_SET: begin
        // on level wins, so a level change cannot release early
        if ((free_cnt > eff_on) & (free_cnt >= eff_off)) begin
          nxt_nf_state = NF_CLEAR;
        end
      end
      default: begin
        nxt_nf_state = NF_CLEAR;
      end
    endcase
  end
  // output flop mirrors the state so the pin comes from a flop
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nf_state_ff <= NF_CLEAR;
      fifo_near_full_low <= 1'b1;
    end else begin
      nf_state_ff <= nxt_nf_state;
      fifo_near_full_low <= ~nxt_nf_state;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // register writes; burst and calendar only change while disabled
  wire cfg_locked;
  assign cfg_locked = source_enable_ctl_ff;
  reg nxt_source_enable_ctl;
  reg nxt_release_policy_select;
  reg [5:0] nxt_max_burst_credits;
  reg [8:0] nxt_near_full_on_level;
  reg [8:0] nxt_near_full_off_level;
  reg [7:0] nxt_calendar_repeat_count;
  reg [8:0] nxt_calendar_sequence_length;
  // enable and levels stay writable so software can always stop the source
  always @* begin
    nxt_source_enable_ctl = source_enable_ctl_ff;
    nxt_release_policy_select = release_policy_select_ff;
    nxt_max_burst_credits = max_burst_credits_ff;
    nxt_near_full_on_level = near_full_on_level_ff;
    nxt_near_full_off_level = near_full_off_level_ff;
    nxt_calendar_repeat_count = calendar_repeat_count_ff;
    nxt_calendar_sequence_length = calendar_sequence_length_ff;
    if (wr_acc) begin
      case (paddr)
        `OFF_CTRL: begin
          nxt_source_enable_ctl = pwdata[`CTRL_ENABLE_BIT];
          nxt_release_policy_select = pwdata[`CTRL_POLICY_BIT];
        end
        `OFF_BURST: begin
          if (!cfg_locked) begin
            nxt_max_burst_credits = pwdata[5:0];
          end
        end
        `OFF_ON_LVL: nxt_near_full_on_level = pwdata[8:0];
        `OFF_OFF_LVL: nxt_near_full_off_level = pwdata[8:0];
        `OFF_CAL: begin
          if (!cfg_locked) begin
            nxt_calendar_repeat_count = pwdata[`CAL_REPEAT_LSB+7:`CAL_REPEAT_LSB];
            nxt_calendar_sequence_length = pwdata[`CAL_LEN_LSB+8:`CAL_LEN_LSB];
          end
        end
        default: begin
        end
      endcase
    end
  end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      source_enable_ctl_ff <= 1'b0;
      release_policy_select_ff <= 1'b0;
      max_burst_credits_ff <= `RST_BURST;
      near_full_on_level_ff <= `RST_ON_LVL;
      near_full_off_level_ff <= `RST_OFF_LVL;
      calendar_repeat_count_ff <= 8'h00;
      calendar_sequence_length_ff <= 9'h000;
    end else begin
      source_enable_ctl_ff <= nxt_source_enable_ctl;
      release_policy_select_ff <= nxt_release_policy_select;
      max_burst_credits_ff <= nxt_max_burst_credits;
      near_full_on_level_ff <= nxt_near_full_on_level;
      near_full_off_level_ff <= nxt_near_full_off_level;
      calendar_repeat_count_ff <= nxt_calendar_repeat_count;
      calendar_sequence_length_ff <= nxt_calendar_sequence_length;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // apb answer: one wait-free access phase
  reg [31:0] nxt_rdata;
  always @* begin
    nxt_rdata = 32'h00000000;
    case (paddr)
      `OFF_CTRL: nxt_rdata = {30'h0, release_policy_select_ff, source_enable_ctl_ff};
      `OFF_BURST: nxt_rdata = {26'h0, max_burst_credits_ff};
      `OFF_ON_LVL: nxt_rdata = {23'h0, near_full_on_level_ff};
      `OFF_OFF_LVL: nxt_rdata = {23'h0, near_full_off_level_ff};
      `OFF_CAL: nxt_rdata = {15'h0, calendar_sequence_length_ff, calendar_repeat_count_ff};
      `OFF_STATUS: nxt_rdata = {12'h0, eff_burst, eop_pending_ff, ~fifo_near_full_low,
                                release_ok, buf_in_ready, 1'b0, used_ff};
      `OFF_EFF_LVL: nxt_rdata = {7'h0, eff_off, 7'h0, eff_on};
      default: nxt_rdata = 32'h00000000;
    endcase
  end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= setup;
      pslverr <= setup & ~hit;
      prdata <= (setup & ~pwrite) ? nxt_rdata : 32'h00000000;
    end
  end
  // reads have no side effect, so no read strobe is decoded
endmodule // source_burst_config
`default_nettype wire
